// ---- rtl/ivt_pkg.sv ----
// Constants for the interval timers and edge interrupt block.
// Assumes a single 250 MHz clock and an 8-bit register port with a 4-bit index.
// Functional notes
// - Port A control inputs are interrupt sources only, each with flag and enable.
// - Each control input sets its flag on the rising or falling edge chosen.
// - Port B control flags 4 and 3 set on edges even while shifting.
// - Port B control lines are never driven as handshake outputs.
// - Timer 1 is a 16-bit counter with two 8-bit latches, slow-tick decrement.
// - Timer 1 wraps past zero to all ones and sets flag 6.
// - One tick after all ones, timer 1 reloads both latches and keeps counting.
// - Both timers time out N+1 ticks after being loaded with N.
// - Aux control bit 7 is hard-wired to zero; line seven stays a port bit.
// - Aux control bit 6 selects one-shot (low) or free-run (high) for timer 1.
// - Low counter write sets low latch; high write loads high latch and counter.
// - After a high counter write, timer 1 decrements on the next slow tick.
// - Flag 6 clears on high latch write, high counter write or low counter read.
// - One-shot timer 1 sets flag 6 once per high counter write.
// - Free-run timer 1 sets flag 6 on every all-ones count.
// - High counter write restarts timing; latch writes only shape the next period.
// - Timer 2 has write-only low latch, read-only low and read/write high counter.
// - Timer 2 is one-shot, sets flag 5 once, then keeps decrementing.
// - Flag 5 clears on low counter read or high counter load; high load re-arms.
// - No pulse counting on line six; it stays an ordinary port bit.
// - The slow tick is derived internally from the block clock.
// - The interrupt request is low while any enabled flag is set.
// - Reset clears control, enable and flag registers, but not counters or latches.
package ivt_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_T1_CNT_LO = 4'h4;
  localparam logic [ADDR_W-1:0] REG_T1_CNT_HI = 4'h5;
  localparam logic [ADDR_W-1:0] REG_T1_LAT_LO = 4'h6;
  localparam logic [ADDR_W-1:0] REG_T1_LAT_HI = 4'h7;
  localparam logic [ADDR_W-1:0] REG_T2_CNT_LO = 4'h8;
  localparam logic [ADDR_W-1:0] REG_T2_CNT_HI = 4'h9;
  localparam logic [ADDR_W-1:0] REG_AUX_CTL = 4'hB;
  localparam logic [ADDR_W-1:0] REG_PERIPH_CTL = 4'hC;
  localparam logic [ADDR_W-1:0] REG_IRQ_FLAG = 4'hD;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 4'hE;
  // Flag and enable bit positions.
  localparam int IRQ_A_TWO_BIT = 0;
  localparam int IRQ_A_ONE_BIT = 1;
  localparam int IRQ_B_TWO_BIT = 3;
  localparam int IRQ_B_ONE_BIT = 4;
  localparam int IRQ_T2_BIT = 5;
  localparam int IRQ_T1_BIT = 6;
  localparam int IRQ_TOP_BIT = 7;
  // Edge select bits in the peripheral control register, 1 = rising edge.
  localparam int PCR_A_ONE_BIT = 0;
  localparam int PCR_A_TWO_BIT = 2;
  localparam int PCR_B_ONE_BIT = 4;
  localparam int PCR_B_TWO_BIT = 6;
  localparam int ACR_FREERUN_BIT = 6;
  localparam logic [DATA_W-1:0] ACR_STORE_MASK = 8'h5F;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Slow tick period and block clock period in picoseconds.
  localparam int TICK_PERIOD_PS = 1276550;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
endpackage

// ---- rtl/ivt_timers.sv ----
// Two 16-bit interval timers and four edge interrupt inputs behind an 8-bit register port.
// Assumes inputs synchronous to I_CLK except the control inputs, which are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module ivt_timers #(
  parameter int TICK_DIV = ivt_pkg::TICK_CYCLES
) (
  input wire logic I_CLK, // Block clock, 250 MHz.
  input wire logic I_RST, // Synchronous reset, active high.
  input wire logic [ivt_pkg::ADDR_W-1:0] I_ADDR, // Register index.
  input wire logic [ivt_pkg::DATA_W-1:0] I_WDATA, // Write data.
  input wire logic I_WR, // Write strobe.
  input wire logic I_RD, // Read strobe.
  output logic [ivt_pkg::DATA_W-1:0] O_RDATA, // Read data, cycle after the read strobe.
  input wire logic I_PORT_A_CTL_IN_ONE, // Port A control input one.
  input wire logic I_PORT_A_CTL_IN_TWO, // Port A control input two.
  input wire logic I_PORT_B_CTL_IN_ONE, // Port B control input one.
  input wire logic I_PORT_B_CTL_IN_TWO, // Port B control input two.
  output logic O_IRQ_N // Interrupt request, active low.
);
  import ivt_pkg::*;

  localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  generate
    if (TICK_DIV < 2) begin : g_bad_div
      $error("TICK_DIV must be at least 2");
    end
  endgenerate

  logic [TW-1:0] tick_cnt_r;
  logic tick;
  logic [15:0] t1_cnt_r;
  logic [7:0] t1_lat_lo_r;
  logic [7:0] t1_lat_hi_r;
  logic t1_reload_r;
  logic t1_armed_r;
  logic [15:0] t2_cnt_r;
  logic [7:0] t2_lat_lo_r;
  logic t2_armed_r;
  logic [7:0] aux_control_reg_r;
  logic [7:0] periph_control_reg_r;
  logic [6:0] irq_flag_reg_r;
  logic [6:0] irq_flag_reg_nxt;
  logic [6:0] irq_enable_reg_r;
  logic [7:0] rdata_r;
  logic [3:0] ctl_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  logic [3:0] ctl_edge;
  logic [3:0] edge_rise_sel;
  logic irq_any;
  logic wr_t1_lat_lo;
  logic wr_t1_cnt_hi;
  logic wr_t1_lat_hi;
  logic rd_t1_cnt_lo;
  logic wr_t2_lat_lo;
  logic wr_t2_cnt_hi;
  logic rd_t2_cnt_lo;
  logic wr_ifr;
  logic t1_wrap;
  logic t2_wrap;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;

  assign wr_t1_lat_lo = I_WR && (I_ADDR == REG_T1_CNT_LO || I_ADDR == REG_T1_LAT_LO);
  assign wr_t1_cnt_hi = I_WR && I_ADDR == REG_T1_CNT_HI;
  assign wr_t1_lat_hi = I_WR && I_ADDR == REG_T1_LAT_HI;
  assign rd_t1_cnt_lo = I_RD && I_ADDR == REG_T1_CNT_LO;
  assign wr_t2_lat_lo = I_WR && I_ADDR == REG_T2_CNT_LO;
  assign wr_t2_cnt_hi = I_WR && I_ADDR == REG_T2_CNT_HI;
  assign rd_t2_cnt_lo = I_RD && I_ADDR == REG_T2_CNT_LO;
  assign wr_ifr = I_WR && I_ADDR == REG_IRQ_FLAG;

  // Slow tick generator running off the block clock.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r == TW'(TICK_DIV - 1));

  // Timer 1 latches; they only shape the next period.
  always_ff @(posedge I_CLK) begin
    if (wr_t1_lat_lo) begin
      t1_lat_lo_r <= I_WDATA;
    end
    if (wr_t1_lat_hi || wr_t1_cnt_hi) begin
      t1_lat_hi_r <= I_WDATA;
    end
  end

  // A high counter write in the same cycle beats the wrap, so a restart is never lost.
  // The tick spent at all ones is a reload tick and must not count as a second wrap.
  assign t1_wrap = tick && !wr_t1_cnt_hi && !t1_reload_r && t1_cnt_r == CNT_ZERO;

  // Timer 1 counter: a high write loads it, then each tick decrements or reloads.
  always_ff @(posedge I_CLK) begin
    if (wr_t1_cnt_hi) begin
      t1_cnt_r <= {I_WDATA, t1_lat_lo_r};
    end else if (tick && t1_reload_r) begin
      t1_cnt_r <= {t1_lat_hi_r, t1_lat_lo_r};
    end else if (tick) begin
      t1_cnt_r <= t1_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || wr_t1_cnt_hi) begin
      t1_reload_r <= 1'b0;
    end else if (tick) begin
      t1_reload_r <= t1_wrap;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      t1_armed_r <= 1'b0;
    end else if (wr_t1_cnt_hi) begin
      t1_armed_r <= 1'b1;
    end else if (t1_wrap) begin
      t1_armed_r <= 1'b0;
    end
  end

  // Timer 2: one-shot flag, the count just rolls on with no reload.
  always_ff @(posedge I_CLK) begin
    if (wr_t2_lat_lo) begin
      t2_lat_lo_r <= I_WDATA;
    end
  end

  assign t2_wrap = tick && !wr_t2_cnt_hi && t2_cnt_r == CNT_ZERO;

  always_ff @(posedge I_CLK) begin
    if (wr_t2_cnt_hi) begin
      t2_cnt_r <= {I_WDATA, t2_lat_lo_r};
    end else if (tick) begin
      t2_cnt_r <= t2_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      t2_armed_r <= 1'b0;
    end else if (wr_t2_cnt_hi) begin
      t2_armed_r <= 1'b1;
    end else if (t2_wrap) begin
      t2_armed_r <= 1'b0;
    end
  end

  // Control inputs: two-stage synchroniser, then an edge stage.
  // Only the second stage feeds the edge stage, since the first may still be settling.
  assign ctl_in = {I_PORT_B_CTL_IN_ONE, I_PORT_B_CTL_IN_TWO,
                   I_PORT_A_CTL_IN_ONE, I_PORT_A_CTL_IN_TWO};
  assign edge_rise_sel = {periph_control_reg_r[PCR_B_ONE_BIT],
                          periph_control_reg_r[PCR_B_TWO_BIT],
                          periph_control_reg_r[PCR_A_ONE_BIT],
                          periph_control_reg_r[PCR_A_TWO_BIT]};
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= ctl_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      // Lines are inputs only; nothing here ever drives them.
      assign ctl_edge[gi] = edge_rise_sel[gi] ? (sync2_r[gi] && !sync3_r[gi]) :
                                                (!sync2_r[gi] && sync3_r[gi]);
    end
  endgenerate

  // Flag register: sources set, software clears, and a set always wins.
  always_comb begin
    flag_set = 7'h00;
    flag_set[IRQ_A_TWO_BIT] = ctl_edge[0];
    flag_set[IRQ_A_ONE_BIT] = ctl_edge[1];
    flag_set[IRQ_B_TWO_BIT] = ctl_edge[2];
    flag_set[IRQ_B_ONE_BIT] = ctl_edge[3];
    flag_set[IRQ_T2_BIT] = t2_wrap && t2_armed_r;
    flag_set[IRQ_T1_BIT] = t1_wrap && (aux_control_reg_r[ACR_FREERUN_BIT] || t1_armed_r);
    flag_clr = wr_ifr ? I_WDATA[6:0] : 7'h00;
    flag_clr[IRQ_T1_BIT] = flag_clr[IRQ_T1_BIT] || wr_t1_cnt_hi || wr_t1_lat_hi || rd_t1_cnt_lo;
    flag_clr[IRQ_T2_BIT] = flag_clr[IRQ_T2_BIT] || wr_t2_cnt_hi || rd_t2_cnt_lo;
    irq_flag_reg_nxt = (irq_flag_reg_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_flag_reg_r <= 7'h00;
    end else begin
      irq_flag_reg_r <= irq_flag_reg_nxt;
    end
  end

  // Enable register: bit 7 of the write selects set or clear of the ones given.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_enable_reg_r <= 7'h00;
    end else if (I_WR && I_ADDR == REG_IRQ_ENABLE) begin
      if (I_WDATA[IRQ_TOP_BIT]) begin
        irq_enable_reg_r <= irq_enable_reg_r | I_WDATA[6:0];
      end else begin
        irq_enable_reg_r <= irq_enable_reg_r & ~I_WDATA[6:0];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      aux_control_reg_r <= REG_RESET;
      periph_control_reg_r <= REG_RESET;
    end else if (I_WR) begin
      if (I_ADDR == REG_AUX_CTL) begin
        aux_control_reg_r <= I_WDATA & ACR_STORE_MASK;
      end
      if (I_ADDR == REG_PERIPH_CTL) begin
        periph_control_reg_r <= I_WDATA;
      end
    end
  end

  assign irq_any = |(irq_flag_reg_r & irq_enable_reg_r);
  assign O_IRQ_N = !irq_any;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge I_CLK) begin
    if (I_RST || !I_RD) begin
      rdata_r <= REG_RESET;
    end else begin
      case (I_ADDR)
        REG_T1_CNT_LO: rdata_r <= t1_cnt_r[7:0];
        REG_T1_CNT_HI: rdata_r <= t1_cnt_r[15:8];
        REG_T1_LAT_LO: rdata_r <= t1_lat_lo_r;
        REG_T1_LAT_HI: rdata_r <= t1_lat_hi_r;
        REG_T2_CNT_LO: rdata_r <= t2_cnt_r[7:0];
        REG_T2_CNT_HI: rdata_r <= t2_cnt_r[15:8];
        REG_AUX_CTL: rdata_r <= aux_control_reg_r;
        REG_PERIPH_CTL: rdata_r <= periph_control_reg_r;
        REG_IRQ_FLAG: rdata_r <= {irq_any, irq_flag_reg_r};
        REG_IRQ_ENABLE: rdata_r <= {1'b1, irq_enable_reg_r};
        default: rdata_r <= REG_RESET;
      endcase
    end
  end
  assign O_RDATA = rdata_r;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  // A flag that already stands and is not cleared simply stays set.
  chk_t1_wrap_ones: assert property (
    t1_wrap |=> t1_cnt_r == CNT_ALL_ONES && t1_reload_r && irq_flag_reg_r[IRQ_T1_BIT] ==
      ($past(aux_control_reg_r[ACR_FREERUN_BIT]) || $past(t1_armed_r) ||
      ($past(irq_flag_reg_r[IRQ_T1_BIT]) && !$past(flag_clr[IRQ_T1_BIT]))))
    else $error("timer 1 wrap did not give all ones with correct flag");
  chk_t1_reload_latch: assert property (
    tick && t1_reload_r && !wr_t1_cnt_hi |=>
      t1_cnt_r == {$past(t1_lat_hi_r), $past(t1_lat_lo_r)})
    else $error("timer 1 did not reload from the latches");
  chk_t1_high_load: assert property (
    wr_t1_cnt_hi |=> t1_cnt_r == {$past(I_WDATA), $past(t1_lat_lo_r)} &&
      t1_lat_hi_r == $past(I_WDATA) && t1_armed_r && !t1_reload_r)
    else $error("timer 1 high counter write did not load");
  chk_t1_first_tick: assert property (
    wr_t1_cnt_hi ##1 (!wr_t1_cnt_hi && tick) |=> t1_cnt_r == $past(t1_cnt_r, 1) - 16'h0001)
    else $error("timer 1 did not decrement on the first tick");
  chk_t1_oneshot_once: assert property (
    !t1_armed_r && !aux_control_reg_r[ACR_FREERUN_BIT] && !irq_flag_reg_r[IRQ_T1_BIT]
      && !wr_ifr |=> !irq_flag_reg_r[IRQ_T1_BIT])
    else $error("one-shot timer 1 set its flag without rearm");
  chk_t1_flag_clear: assert property (
    (wr_t1_lat_hi || wr_t1_cnt_hi || rd_t1_cnt_lo) && !t1_wrap |=> !irq_flag_reg_r[IRQ_T1_BIT])
    else $error("timer 1 flag not cleared by access");
  chk_t2_roll_on: assert property (
    tick && !wr_t2_cnt_hi && t2_cnt_r == CNT_ALL_ONES |=> t2_cnt_r == 16'hFFFE)
    else $error("timer 2 did not keep decrementing past all ones");
  chk_t2_flag_clear: assert property (
    (rd_t2_cnt_lo || wr_t2_cnt_hi) && !(t2_wrap && t2_armed_r) |=>
      !irq_flag_reg_r[IRQ_T2_BIT] ##1
      (!irq_flag_reg_r[IRQ_T2_BIT] || $past(t2_wrap)))
    else $error("timer 2 flag not cleared by access");
  chk_edge_sets_flag: assert property (
    $rose(sync2_r[1]) && periph_control_reg_r[PCR_A_ONE_BIT] |=> irq_flag_reg_r[IRQ_A_ONE_BIT])
    else $error("rising edge on port A input one did not set its flag");
  chk_set_wins: assert property (
    ctl_edge[3] && wr_ifr && I_WDATA[IRQ_B_ONE_BIT] |=> irq_flag_reg_r[IRQ_B_ONE_BIT])
    else $error("flag set lost against a clear");
  chk_irq_follows: assert property (
    $rose(irq_flag_reg_r[IRQ_T2_BIT]) && irq_enable_reg_r[IRQ_T2_BIT] |-> !O_IRQ_N)
    else $error("interrupt request not asserted for enabled flag");
  chk_acr_top_zero: assert property (
    I_RD && I_ADDR == REG_AUX_CTL |=> !O_RDATA[7] && !O_RDATA[5])
    else $error("aux control hard-wired bits read nonzero");
  // Further guards for loading, quiet latch writes, the tick and the edge stage.
  chk_t2_high_load: assert property (
    wr_t2_cnt_hi |=> t2_cnt_r == {$past(I_WDATA), $past(t2_lat_lo_r)} && t2_armed_r)
    else $error("timer 2 high counter write did not load");
  chk_t1_latch_quiet: assert property (
    (wr_t1_lat_lo || wr_t1_lat_hi) && !tick |=> $stable(t1_cnt_r))
    else $error("timer 1 latch write disturbed the count");
  chk_t1_freerun_flag: assert property (
    t1_wrap && aux_control_reg_r[ACR_FREERUN_BIT] |=> irq_flag_reg_r[IRQ_T1_BIT])
    else $error("free-run timer 1 wrap did not set its flag");
  chk_b_edge_flag: assert property (
    ctl_edge[2] |=> irq_flag_reg_r[IRQ_B_TWO_BIT])
    else $error("edge on port B input two did not set its flag");
  chk_irq_quiet: assert property (
    irq_flag_reg_r == 7'h00 |-> O_IRQ_N)
    else $error("interrupt request asserted with no flag set");
  chk_reset_clears: assert property (
    $past(I_RST) |-> irq_flag_reg_r == 7'h00 && irq_enable_reg_r == 7'h00 &&
      aux_control_reg_r == REG_RESET && periph_control_reg_r == REG_RESET)
    else $error("reset left a control, enable or flag register set");
  chk_tick_spaced: assert property (
    tick |=> !tick)
    else $error("slow tick came on two clocks in a row");
  chk_edge_once: assert property (
    ctl_edge[1] ##1 $stable(periph_control_reg_r) |-> !ctl_edge[1])
    else $error("one input edge was seen twice");

  cov_t1_freerun: cover property (
    aux_control_reg_r[ACR_FREERUN_BIT] && t1_wrap ##[1:1000] t1_wrap);
  cov_t2_timeout: cover property (wr_t2_cnt_hi ##[1:1000] $rose(irq_flag_reg_r[IRQ_T2_BIT]));
  cov_b_edge: cover property ($rose(irq_flag_reg_r[IRQ_B_TWO_BIT]));
  cov_irq_low: cover property ($fell(O_IRQ_N));
  cov_set_clash: cover property (ctl_edge[3] && wr_ifr && I_WDATA[IRQ_B_ONE_BIT]);
endmodule
`default_nettype wire

// ---- verif/ivt_edge_src.sv ----
// Peripheral side model that drives the four edge interrupt lines.
// Assumes the bench asks for levels; the lines change just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ivt_edge_src (
  input wire logic i_clk, // Bench clock.
  input wire logic [3:0] i_lvl, // Wanted levels: A one, A two, B one, B two.
  output logic [3:0] o_line // Control lines toward the block.
);
  initial o_line = 4'h0;
  always @(posedge i_clk) begin
    o_line <= i_lvl;
  end
endmodule
`default_nettype wire

// ---- verif/ivt_timers_bench.sv ----
// Self-checking bench for the interval timers and edge interrupt block.
// Assumes the edge source model and a tick divider shortened to 4 clocks.
`timescale 1ns/10ps
`default_nettype none
module ivt_timers_bench;
  import ivt_pkg::*;
  localparam int DIV = 4;
  logic I_CLK, I_RST, I_WR, I_RD, O_IRQ_N;
  logic [ADDR_W-1:0] I_ADDR;
  logic [DATA_W-1:0] I_WDATA, O_RDATA, rd;
  logic [3:0] lvl, line;
  logic [31:0] seed;
  int num_errors = 0, n_checks = 0, cyc = 0, t0, w, n, m, pol, fb;
  ivt_edge_src u_src (.i_clk(I_CLK), .i_lvl(lvl), .o_line(line));
  ivt_timers #(.TICK_DIV(DIV)) u_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_PORT_A_CTL_IN_ONE(line[0]), .I_PORT_A_CTL_IN_TWO(line[1]),
    .I_PORT_B_CTL_IN_ONE(line[2]), .I_PORT_B_CTL_IN_TWO(line[3]), .O_IRQ_N(O_IRQ_N));
  initial begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  function automatic int rnd(input int lim);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed[15:0]) % lim;
  endfunction
  // Flag bit and edge select bit of each control line.
  function automatic int flag_of(input int i);
    int t[4] = '{IRQ_A_ONE_BIT, IRQ_A_TWO_BIT, IRQ_B_ONE_BIT, IRQ_B_TWO_BIT};
    return t[i];
  endfunction
  function automatic int sel_of(input int i);
    int t[4] = '{PCR_A_ONE_BIT, PCR_A_TWO_BIT, PCR_B_ONE_BIT, PCR_B_TWO_BIT};
    return t[i];
  endfunction
  // One when a timeout after a load of nv falls in the window of tick phases.
  function automatic logic [7:0] in_win(input int wv, input int nv);
    return {7'h0, (wv >= DIV * nv + 1) && (wv <= DIV * nv + DIV + 1)};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 rd = O_RDATA;
  endtask
  // Counts edges until the request goes low, bounded.
  task automatic wirq(output int wv);
    wv = 0;
    #1;
    while (O_IRQ_N !== 1'b0 && wv < 2000) begin
      @(posedge I_CLK);
      #1 wv++;
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask
  task automatic reg_defaults();
    rdr(REG_IRQ_FLAG);
    check(rd, 8'h00);
    rdr(REG_IRQ_ENABLE);
    check(rd, 8'h80);
    rdr(REG_AUX_CTL);
    check(rd, 8'h00);
    rdr(REG_PERIPH_CTL);
    check(rd, 8'h00);
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h86f6_9839;
    I_RST = 1'b1;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 4'h0;
    I_WDATA = 8'h00;
    lvl = 4'h0;
    repeat (12) @(posedge I_CLK);
    I_RST <= 1'b0;
    reg_defaults();
    rdr(4'hF);
    check(rd, 8'h00);
    check({7'h0, O_IRQ_N}, 8'h01);
    wr(REG_AUX_CTL, 8'hFF);
    rdr(REG_AUX_CTL);
    check(rd, 8'h5F);
    // Free-run must not stay on while timer 1 holds no loaded count yet.
    wr(REG_AUX_CTL, 8'h00);
    wr(REG_IRQ_ENABLE, 8'hFF);
    // Each line: a rise then a fall, only the selected edge may set the flag.
    for (int i = 0; i < 4; i++) begin
      pol = rnd(2);
      fb = flag_of(i);
      wr(REG_PERIPH_CTL, 8'(pol << sel_of(i)));
      for (int e = 0; e < 2; e++) begin
        wr(REG_IRQ_FLAG, 8'h7F);
        @(posedge I_CLK);
        lvl[i] <= (e == 0);
        wait_cyc(8);
        m = (e == 0) ? pol : 1 - pol;
        check({7'h0, O_IRQ_N}, 8'(1 - m));
        rdr(REG_IRQ_FLAG);
        check(rd, m ? 8'(8'h80 | (1 << fb)) : 8'h00);
      end
    end
    wr(REG_PERIPH_CTL, 8'h00);
    @(posedge I_CLK);
    lvl[0] <= 1'b1;
    wait_cyc(4);
    @(posedge I_CLK);
    lvl[0] <= 1'b0;
    wait_cyc(8);
    wr(REG_IRQ_ENABLE, 8'h02);
    rdr(REG_IRQ_FLAG);
    check(rd, 8'h02);
    check({7'h0, O_IRQ_N}, 8'h01);
    wr(REG_IRQ_ENABLE, 8'h82);
    wr(REG_IRQ_FLAG, 8'h02);
    rdr(REG_IRQ_FLAG);
    check(rd, 8'h00);
    // A flag clear landing on the edge that sets the flag must lose.
    wr(REG_PERIPH_CTL, 8'h10);
    @(posedge I_CLK);
    lvl[2] <= 1'b1;
    repeat (2) @(posedge I_CLK);
    wr(REG_IRQ_FLAG, 8'h10);
    rdr(REG_IRQ_FLAG);
    check(rd, 8'h90);
    wr(REG_IRQ_FLAG, 8'h10);
    // Timer 1 one-shot, a load of zero first.
    wr(REG_AUX_CTL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? 0 : rnd(8) + 1;
      wr(REG_T1_CNT_LO, 8'(n));
      wr(REG_T1_CNT_HI, 8'h00);
      wirq(w);
      check(in_win(w, n), 8'h01);
      rdr(REG_IRQ_FLAG);
      check(rd, 8'hC0);
      rdr(REG_T1_CNT_LO);
      rdr(REG_IRQ_FLAG);
      check(rd, 8'h00);
      wait_cyc(DIV * (n + 2) * 2);
      rdr(REG_IRQ_FLAG);
      check(rd, 8'h00);
    end
    // Timer 1 free-run: the latch write in period two shapes period three.
    wr(REG_AUX_CTL, 8'h40);
    n = rnd(4) + 4;
    m = rnd(4) + 4;
    wr(REG_T1_LAT_LO, 8'(n));
    wr(REG_T1_CNT_HI, 8'h00);
    for (int p = 0; p < 3; p++) begin
      wirq(w);
      if (p > 0) begin
        check(8'(cyc - t0), 8'(DIV * ((p == 2 ? m : n) + 2)));
      end
      t0 = cyc;
      wr(REG_T1_LAT_HI, 8'h00);
      if (p == 0) begin
        wait_cyc(6);
        wr(REG_T1_LAT_LO, 8'(m));
      end
    end
    wr(REG_AUX_CTL, 8'h00);
    wr(REG_IRQ_ENABLE, 8'h40);
    // Timer 2 one-shot, loaded twice to show the re-arm.
    for (int k = 0; k < 2; k++) begin
      n = rnd(8);
      wr(REG_T2_CNT_LO, 8'(n));
      wr(REG_T2_CNT_HI, 8'h00);
      wirq(w);
      check(in_win(w, n), 8'h01);
      rdr(REG_IRQ_FLAG);
      check(rd & 8'hA0, 8'hA0);
      rdr(REG_T2_CNT_LO);
      rdr(REG_IRQ_FLAG);
      check(rd & 8'h20, 8'h00);
      wait_cyc(DIV * 3);
      rdr(REG_T2_CNT_HI);
      check(rd, 8'hFF);
    end
    // Reset in mid-run keeps the latches.
    wr(REG_T1_LAT_HI, 8'h5A);
    @(posedge I_CLK);
    I_RST <= 1'b1;
    wait_cyc(3);
    @(posedge I_CLK);
    I_RST <= 1'b0;
    reg_defaults();
    rdr(REG_T1_LAT_HI);
    check(rd, 8'h5A);
    final_report();
  end
endmodule
`default_nettype wire
